// file: rtl/pcacr_defines.svh
`ifndef PCACR_DEFINES_SVH
`define PCACR_DEFINES_SVH
// Register offsets are word indices; the bus byte address is four times the index.
`define PCACR_OFF_MODE      8'hdc
`define PCACR_OFF_LOW       8'heb
`define PCACR_OFF_HIGH      8'hec
`define PCACR_OFF_STATUS    8'hf0
`define PCACR_OFF_MASK      8'hf4
`define PCACR_OFF_SELECT    8'hf8
`define PCACR_BIT_WIDE      7
`define PCACR_BIT_COMP_EN   6
`define PCACR_BIT_RISE_CAP  5
`define PCACR_BIT_FALL_CAP  4
`define PCACR_BIT_MATCH     3
`define PCACR_BIT_TOGGLE    2
`define PCACR_BIT_PWM       1
`define PCACR_BIT_FLAG_MASK 0
`define PCACR_RESET_BYTE    8'h00
`define PCACR_RESP_OKAY     2'b00
`define PCACR_RESP_SLVERR   2'b10
`endif

// file: rtl/pcacr_pkg.sv
package pcacr_pkg;
    typedef struct packed {
        logic       wide_pulse_mode_select;
        logic       comparator_function_enable;
        logic       rising_edge_capture_enable;
        logic       falling_edge_capture_enable;
        logic       match_function_enable;
        logic       toggle_function_enable;
        logic       pwm_mode_enable;
        logic       flag_interrupt_mask;
    } pcacr_mode_t;
    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } pcacr_value_t;
endpackage

// file: rtl/pcacr_channel2_regs.sv
// Function
// - A software write to the low byte forces the comparator enable bit to 0.
// - The low byte holds bits 7:0 of the 16-bit compare value and resets to zero.
// - The high byte holds the upper byte of the 16-bit compare value and resets to zero.
// - The byte addresses alternatively reach the auto-reload bytes used in 9 to 11-bit PWM.
// - The reload select bit chooses between compare bytes and auto-reload bytes.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pcacr_defines.svh"
module pcacr_channel2_regs
    import pcacr_pkg::*;
(
    // Clock and reset.
    input  wire logic         clock_in,
    input  wire logic         reset_in,
    // AXI4-Lite write channels.
    input  wire logic [9:0]   s_axi_awaddr_in,
    input  wire logic         s_axi_awvalid_in,
    output logic              s_axi_awready_out,
    input  wire logic [31:0]  s_axi_wdata_in,
    input  wire logic [3:0]   s_axi_wstrb_in,
    input  wire logic         s_axi_wvalid_in,
    output logic              s_axi_wready_out,
    output logic [1:0]        s_axi_bresp_out,
    output logic              s_axi_bvalid_out,
    input  wire logic         s_axi_bready_in,
    // AXI4-Lite read channels.
    input  wire logic [9:0]   s_axi_araddr_in,
    input  wire logic         s_axi_arvalid_in,
    output logic              s_axi_arready_out,
    output logic [31:0]       s_axi_rdata_out,
    output logic [1:0]        s_axi_rresp_out,
    output logic              s_axi_rvalid_out,
    input  wire logic         s_axi_rready_in,
    // Counter array side.
    input  wire logic         event_flag_in,
    output pcacr_mode_t       mode_out,
    output pcacr_value_t      compare_value_out,
    output pcacr_value_t      reload_value_out,
    output logic              interrupt_out
);
    pcacr_mode_t  mode_reg, mode_next;
    pcacr_value_t cmp_reg, cmp_next, rld_reg, rld_next;
    logic         sel_reg, sel_next, stat_reg, stat_next, msk_reg, msk_next;
    logic         irq_reg, irq_next;
    logic         aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
    logic         awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, arrdy_reg, arrdy_next;
    logic [7:0]   awa_reg, awa_next;
    logic [7:0]   wd_reg, wd_next;
    logic         we_reg, we_next;
    logic [1:0]   br_reg, br_next, rr_reg, rr_next;
    logic [7:0]   rd_reg, rd_next;
    logic         do_wr;
    logic [7:0]   wa;

    always_comb begin
        aw_next   = aw_reg;
        w_next    = w_reg;
        awa_next  = awa_reg;
        wd_next   = wd_reg;
        we_next   = we_reg;
        b_next    = b_reg;
        br_next   = br_reg;
        r_next    = r_reg;
        rr_next   = rr_reg;
        rd_next   = rd_reg;
        mode_next = mode_reg;
        cmp_next  = cmp_reg;
        rld_next  = rld_reg;
        sel_next  = sel_reg;
        msk_next  = msk_reg;
        stat_next = stat_reg;
        if (s_axi_awvalid_in && !aw_reg && !b_reg) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr_in[9:2];
        end
        if (s_axi_wvalid_in && !w_reg && !b_reg) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata_in[7:0];
            we_next = s_axi_wstrb_in[0];
        end
        do_wr = aw_reg && w_reg && !b_reg;
        wa    = awa_reg;
        if (do_wr) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            b_next  = 1'b1;
            br_next = `PCACR_RESP_OKAY;
            if (wa == `PCACR_OFF_MODE) begin
                if (we_reg) mode_next = pcacr_mode_t'(wd_reg);
            end else if (wa == `PCACR_OFF_LOW) begin
                if (we_reg && sel_reg) rld_next.low_byte = wd_reg;
                if (we_reg && !sel_reg) cmp_next.low_byte = wd_reg;
                if (we_reg) mode_next.comparator_function_enable = 1'b0;
            end else if (wa == `PCACR_OFF_HIGH) begin
                if (we_reg && sel_reg) rld_next.high_byte = wd_reg;
                if (we_reg && !sel_reg) cmp_next.high_byte = wd_reg;
                if (we_reg) mode_next.comparator_function_enable = 1'b1;
            end else if (wa == `PCACR_OFF_STATUS) begin
                if (we_reg && wd_reg[0]) stat_next = 1'b0;
            end else if (wa == `PCACR_OFF_MASK) begin
                if (we_reg) msk_next = wd_reg[0];
            end else if (wa == `PCACR_OFF_SELECT) begin
                if (we_reg) sel_next = wd_reg[0];
            end else begin
                br_next = `PCACR_RESP_SLVERR;
            end
        end
        if (event_flag_in) stat_next = 1'b1;
        if (b_reg && s_axi_bready_in) b_next = 1'b0;
        if (r_reg && s_axi_rready_in) r_next = 1'b0;
        if (s_axi_arvalid_in && !r_reg) begin
            r_next  = 1'b1;
            rr_next = `PCACR_RESP_OKAY;
            unique case (s_axi_araddr_in[9:2])
                `PCACR_OFF_MODE:   rd_next = mode_reg;
                `PCACR_OFF_LOW:    rd_next = sel_reg ? rld_reg.low_byte : cmp_reg.low_byte;
                `PCACR_OFF_HIGH:   rd_next = sel_reg ? rld_reg.high_byte : cmp_reg.high_byte;
                `PCACR_OFF_STATUS: rd_next = {7'h00, stat_reg};
                `PCACR_OFF_MASK:   rd_next = {7'h00, msk_reg};
                `PCACR_OFF_SELECT: rd_next = {7'h00, sel_reg};
                default: begin
                    rd_next = `PCACR_RESET_BYTE;
                    rr_next = `PCACR_RESP_SLVERR;
                end
            endcase
        end
        irq_next = (stat_next && msk_next) && mode_next.flag_interrupt_mask;
        // Ready outputs are registered copies of the next channel state.
        awrdy_next = !aw_next && !b_next;
        wrdy_next  = !w_next && !b_next;
        arrdy_next = !r_next;
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            mode_reg <= pcacr_mode_t'(`PCACR_RESET_BYTE);
            cmp_reg  <= '0;
            rld_reg  <= '0;
            sel_reg  <= 1'b0;
            stat_reg <= 1'b0;
            msk_reg  <= 1'b0;
            irq_reg  <= 1'b0;
            awrdy_reg <= 1'b1;
            wrdy_reg  <= 1'b1;
            arrdy_reg <= 1'b1;
            aw_reg   <= 1'b0;
            w_reg    <= 1'b0;
            awa_reg  <= 8'h00;
            wd_reg   <= 8'h00;
            we_reg   <= 1'b0;
            b_reg    <= 1'b0;
            br_reg   <= 2'b00;
            r_reg    <= 1'b0;
            rr_reg   <= 2'b00;
            rd_reg   <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            cmp_reg  <= cmp_next;
            rld_reg  <= rld_next;
            sel_reg  <= sel_next;
            stat_reg <= stat_next;
            msk_reg  <= msk_next;
            irq_reg  <= irq_next;
            awrdy_reg <= awrdy_next;
            wrdy_reg  <= wrdy_next;
            arrdy_reg <= arrdy_next;
            aw_reg   <= aw_next;
            w_reg    <= w_next;
            awa_reg  <= awa_next;
            wd_reg   <= wd_next;
            we_reg   <= we_next;
            b_reg    <= b_next;
            br_reg   <= br_next;
            r_reg    <= r_next;
            rr_reg   <= rr_next;
            rd_reg   <= rd_next;
        end
    end

    assign s_axi_awready_out = awrdy_reg;
    assign s_axi_wready_out  = wrdy_reg;
    assign s_axi_bvalid_out  = b_reg;
    assign s_axi_bresp_out   = br_reg;
    assign s_axi_arready_out = arrdy_reg;
    assign s_axi_rvalid_out  = r_reg;
    assign s_axi_rresp_out   = rr_reg;
    assign s_axi_rdata_out   = {24'h000000, rd_reg};
    assign mode_out          = mode_reg;
    assign compare_value_out = cmp_reg;
    assign reload_value_out  = rld_reg;
    assign interrupt_out     = irq_reg;

    chk_low_clears_en: assert property (@(posedge clock_in) disable iff (reset_in)
        (do_wr && we_reg && wa == `PCACR_OFF_LOW)
        |=> !mode_reg.comparator_function_enable)
        else $error("low byte write did not clear comparator enable");
    chk_high_sets_en: assert property (@(posedge clock_in) disable iff (reset_in)
        (do_wr && we_reg && wa == `PCACR_OFF_HIGH)
        |=> mode_reg.comparator_function_enable)
        else $error("high byte write did not set comparator enable");
    chk_irq_masked: assert property (@(posedge clock_in) disable iff (reset_in)
        interrupt_out |-> (stat_reg && mode_reg.flag_interrupt_mask))
        else $error("interrupt raised while masked");
    chk_low_store: assert property (@(posedge clock_in) disable iff (reset_in)
        (do_wr && we_reg && !sel_reg && wa == `PCACR_OFF_LOW)
        |=> cmp_reg.low_byte == $past(wd_reg))
        else $error("low compare byte not stored");
    chk_high_store: assert property (@(posedge clock_in) disable iff (reset_in)
        (do_wr && we_reg && !sel_reg && wa == `PCACR_OFF_HIGH)
        |=> cmp_reg.high_byte == $past(wd_reg))
        else $error("high compare byte not stored");
    chk_reload_route: assert property (@(posedge clock_in) disable iff (reset_in)
        (do_wr && sel_reg && wa == `PCACR_OFF_LOW)
        |=> $stable(cmp_reg.low_byte))
        else $error("reload access altered compare byte");
endmodule // pcacr_channel2_regs

// file: test/pcacr_channel2_regs_tb_top.sv
`timescale 1ns/1ps
`include "pcacr_defines.svh"
module pcacr_channel2_regs_tb_top
    import pcacr_pkg::*;
;
    logic         clock_in   = 1'b0;
    logic         reset_in   = 1'b1;
    logic [9:0]   awaddr     = 10'h000;
    logic         awvalid    = 1'b0;
    logic [31:0]  wdata      = 32'h0;
    logic         wvalid     = 1'b0;
    logic         bready     = 1'b0;
    logic [9:0]   araddr     = 10'h000;
    logic         arvalid    = 1'b0;
    logic         rready     = 1'b0;
    logic         event_flag = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]   bresp, rresp, rsp;
    logic [31:0]  rdata, rd_val;
    pcacr_mode_t  mode;
    pcacr_value_t cmp_val, rld_val;
    int           fails      = 0;
    int           cmp_count  = 0;

    always #2.5 clock_in = ~clock_in;

    pcacr_channel2_regs dut (
        .clock_in(clock_in), .reset_in(reset_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .event_flag_in(event_flag),
        .mode_out(mode), .compare_value_out(cmp_val), .reload_value_out(rld_val),
        .interrupt_out(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("TB: compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Write one byte; address and data are offered together and released when taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        awaddr  <= {a, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_in);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                rsp = bresp;
                break;
            end
        end
        bready <= 1'b0;
        if (n == 40) begin
            fails++;
        end
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        araddr  <= {a, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_in);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rsp    = rresp;
                rd_val = rdata;
                break;
            end
        end
        rready <= 1'b0;
        if (n == 40) begin
            fails++;
        end
        @(posedge clock_in);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask

    initial begin
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        @(posedge clock_in);
        rchk(`PCACR_OFF_LOW, 32'h0);
        rchk(`PCACR_OFF_HIGH, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("TB: reset test done");
        wr(`PCACR_OFF_MODE, 8'h41);
        wr(`PCACR_OFF_LOW, 8'h5a);
        chk({30'h0, rsp}, {30'h0, `PCACR_RESP_OKAY});
        chk({24'h0, mode}, 32'h01);
        rchk(`PCACR_OFF_MODE, 32'h01);
        wr(`PCACR_OFF_HIGH, 8'ha5);
        rchk(`PCACR_OFF_MODE, 32'h41);
        chk({16'h0, cmp_val}, 32'ha55a);
        rchk(`PCACR_OFF_LOW, 32'h5a);
        rchk(`PCACR_OFF_HIGH, 32'ha5);
        $display("TB: compare byte test done");
        wr(`PCACR_OFF_SELECT, 8'h01);
        wr(`PCACR_OFF_LOW, 8'h11);
        wr(`PCACR_OFF_HIGH, 8'h22);
        chk({16'h0, rld_val}, 32'h2211);
        chk({16'h0, cmp_val}, 32'ha55a);
        rchk(`PCACR_OFF_LOW, 32'h11);
        wr(`PCACR_OFF_SELECT, 8'h00);
        rchk(`PCACR_OFF_HIGH, 32'ha5);
        $display("TB: reload select test done");
        wr(`PCACR_OFF_MASK, 8'h01);
        event_flag <= 1'b1;
        @(posedge clock_in);
        event_flag <= 1'b0;
        rchk(`PCACR_OFF_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`PCACR_OFF_MODE, 8'h40);
        rchk(`PCACR_OFF_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`PCACR_OFF_MODE, 8'h41);
        rchk(`PCACR_OFF_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`PCACR_OFF_STATUS, 8'h01);
        rchk(`PCACR_OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`PCACR_OFF_MASK, 8'h00);
        event_flag <= 1'b1;
        @(posedge clock_in);
        event_flag <= 1'b0;
        rchk(`PCACR_OFF_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`PCACR_OFF_STATUS, 8'h01);
        $display("TB: interrupt test done");
        rd(8'h00);
        chk({30'h0, rsp}, {30'h0, `PCACR_RESP_SLVERR});
        chk(rd_val, 32'h0);
        wr(8'h00, 8'hff);
        chk({30'h0, rsp}, {30'h0, `PCACR_RESP_SLVERR});
        $display("TB: unmapped test done");
        end_sim();
    end
endmodule // pcacr_channel2_regs_tb_top
